// [core/soac_params.svh]
// soac_params.svh: constants of the sensor output / alarm configuration block
// assumes: included by the design files of the block
`ifndef SOAC_PARAMS_SVH
`define SOAC_PARAMS_SVH

// output path selection codes
`define SOAC_OUTSEL_I2C        2'h0
`define SOAC_OUTSEL_SPI        2'h1
`define SOAC_OUTSEL_PDM        2'h2
// resolution codes
`define SOAC_RES_10            2'h0
`define SOAC_RES_12            2'h1
`define SOAC_RES_14            2'h2
// result widths per resolution
`define SOAC_BITS_10           5'h0a
`define SOAC_BITS_12           5'h0c
`define SOAC_BITS_14           5'h0e
// conversion times in cycles per resolution (scaled for the model)
`define SOAC_CONV_CYC_10       16'h0010
`define SOAC_CONV_CYC_12       16'h0040
`define SOAC_CONV_CYC_14       16'h0100
// measurement value width
`define SOAC_DATA_W            14

`endif

// [core/soac_pkg.sv]
// soac_pkg.sv: types of the sensor output / alarm configuration block
// assumes: compiled before the design modules
package soac_pkg;
  typedef enum logic [2:0] {
    SOAC_IDLE    = 3'b001,
    SOAC_CONVERT = 3'b010,
    SOAC_DONE    = 3'b100
  } soac_state_t;
endpackage

// [core/soac_alarm.sv]
// soac_alarm.sv: one threshold alarm with hysteresis, polarity and drive option
// assumes: measurement value updates with a one-cycle strobe
`timescale 1ns/1ps
`include "soac_params.svh"
module soac_alarm #(
  parameter int W = `SOAC_DATA_W
) (
  input  wire logic         i_clock,      // clock
  input  wire logic         i_resetn,     // async reset, active low
  input  wire logic         i_enable,     // alarm usable
  input  wire logic         i_is_high,    // 1: high alarm, 0: low alarm
  input  wire logic [W-1:0] i_trip,       // trip point
  input  wire logic [W-1:0] i_hyst,       // hysteresis amount
  input  wire logic         i_polarity,   // 0 active high
  input  wire logic         i_open_drain, // 0 push-pull
  input  wire logic         i_strobe,     // new value present
  input  wire logic [W-1:0] i_value,      // corrected measurement
  output logic              o_pin,        // pin output level
  output logic              o_pin_oe,     // pin output enable
  output logic              o_active      // alarm condition
);
  logic         active;
  logic [W:0]   release_hi;
  logic [W:0]   release_lo;

  // widened so trip + hysteresis never wraps and a trip - hysteresis borrow shows in bit W
  assign release_hi = {1'b0, i_trip} - {1'b0, i_hyst};
  assign release_lo = {1'b0, i_trip} + {1'b0, i_hyst};

  // ==================================================
  // alarm state
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      active <= 1'b0;
    end else if (!i_enable) begin
      active <= 1'b0;
    end else if (i_strobe) begin
      if (i_is_high) begin
        if (i_value > i_trip)                                          // [R1]
          active <= 1'b1;
        else if (release_hi[W] || {1'b0, i_value} <= release_hi)       // [R16]
          active <= active && release_hi[W] ? 1'b1 : 1'b0;
      end else begin
        if (i_value < i_trip)                                          // [R2]
          active <= 1'b1;
        else if (!release_lo[W] && {1'b0, i_value} >= release_lo)      // [R16]
          active <= 1'b0;
      end
    end
  end

  // ==================================================
  // pin drive
  logic level;
  assign level = active ^ i_polarity;                                  // [R4]
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pin    <= 1'b0;
      o_pin_oe <= 1'b0;
      o_active <= 1'b0;
    end else begin
      o_active <= active;
      // open drain only ever pulls low
      o_pin    <= i_open_drain ? 1'b0 : level;
      o_pin_oe <= i_enable && (i_open_drain ? !level : 1'b1);          // [R5]
    end
  end

  a_high_sets: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_enable && i_is_high && i_strobe && i_value > i_trip |=> active)  // [R1]
    else $error("high alarm did not set");
  a_low_sets: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_enable && !i_is_high && i_strobe && i_value < i_trip |=> active) // [R2]
    else $error("low alarm did not set");
  a_polarity_level: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_enable && !i_open_drain && !i_polarity && active |=> o_pin && o_pin_oe) // [R4]
    else $error("active-high alarm pin not high");
  a_pushpull_drive: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_enable && !i_open_drain |=> o_pin_oe)                            // [R5]
    else $error("push-pull pin not driven");
  a_hyst_hold: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_enable && i_is_high && active && i_strobe && i_value > release_hi[W-1:0]
    && !release_hi[W] |=> active)                                      // [R16]
    else $error("high alarm released inside hysteresis");
endmodule // soac_alarm

// [core/soac_top.sv]
// soac_top.sv: output path, mode and alarm configuration of the sensor conditioner
// assumes: configuration bits are static ports, synchronous to i_clock
//
// What this block does
// R1: high alarm asserts above high trip point
// R2: low alarm asserts below low trip point
// R3: host programs trip and hysteresis first
// R4: polarity 0 makes alarm active-high
// R5: open-drain 0 means push-pull drive
// R6: PDM path may drop one alarm
// R7: no serial host means Update Mode
// R8: phase 1: master samples MISO falling
// R9: lock off: acknowledge any I2C address
// R10: ready output has open-drain option
// R11: differential bit selects differential conversion
// R12: differential needs reference/offset caps zero
// R13: selectable 10/12/14-bit conversion resolution
// R14: PDM output forces Update Mode
// R15: select code 10 routes to PDM
// R16: alarm releases only past hysteresis
`timescale 1ns/1ps
`include "soac_params.svh"
module soac_top #(
  parameter int W = `SOAC_DATA_W
) (
  input  wire logic         i_clock,          // 200 MHz clock
  input  wire logic         i_resetn,         // async reset, active low
  input  wire logic [1:0]   i_output_select,  // 0 I2C, 1 SPI, 2 PDM
  input  wire logic         i_sleep_mode,     // 1 Sleep Mode requested
  input  wire logic         i_host_present,   // serial host attached
  input  wire logic         i_measure_cmd,    // measurement command pulse
  input  wire logic         i_spi_phase,      // SPI clock phase
  input  wire logic         i_sclk,           // SPI clock sampled
  input  wire logic         i_addr_lock,      // 1 respond only own address
  input  wire logic [6:0]   i_own_addr,       // programmed I2C address
  input  wire logic [6:0]   i_rx_addr,        // received I2C address
  input  wire logic         i_addr_valid,     // address byte received pulse
  input  wire logic         i_ready_od,       // ready pin open-drain
  input  wire logic         i_differential,   // differential input
  input  wire logic [3:0]   i_ref_cap_sel,    // reference cap selection
  input  wire logic [3:0]   i_offset_cap_sel, // offset cap selection
  input  wire logic [1:0]   i_cap_res,        // capacitance resolution code
  input  wire logic [1:0]   i_temp_res,       // temperature resolution code
  input  wire logic [W-1:0] i_cap_single,     // single-ended raw capacitance
  input  wire logic [W-1:0] i_cap_pos,        // differential positive
  input  wire logic [W-1:0] i_cap_neg,        // differential negative
  input  wire logic [W-1:0] i_temp_raw,       // raw temperature
  input  wire logic [W-1:0] i_high_trip,      // high trip point
  input  wire logic [W-1:0] i_high_hyst,      // high hysteresis
  input  wire logic [W-1:0] i_low_trip,       // low trip point
  input  wire logic [W-1:0] i_low_hyst,       // low hysteresis
  input  wire logic         i_high_pol,       // high alarm polarity
  input  wire logic         i_low_pol,        // low alarm polarity
  input  wire logic         i_high_od,        // high alarm open-drain
  input  wire logic         i_low_od,         // low alarm open-drain
  input  wire logic         i_pdm_one_alarm,  // PDM setup uses a low alarm pin
  output logic              o_alarm_high,     // high alarm pin level
  output logic              o_alarm_high_oe,  // high alarm pin enable
  output logic              o_alarm_low,      // low alarm pin level
  output logic              o_alarm_low_oe,   // low alarm pin enable
  output logic              o_ready,          // ready pin level
  output logic              o_ready_oe,       // ready pin enable
  output logic              o_update_mode,    // effective Update Mode
  output logic              o_config_error,   // sleep without host or pdm, bad caps
  output logic              o_addr_ack,       // I2C address acknowledge pulse
  output logic              o_miso_shift,     // MISO change strobe
  output logic [W-1:0]      o_cap_result,     // corrected capacitance
  output logic [W-1:0]      o_temp_result,    // corrected temperature
  output logic              o_pdm_valid,      // results routed to PDM
  output logic              o_serial_valid    // results routed to serial
);
  soac_pkg::soac_state_t state;
  logic [15:0]          cnt;
  logic [W-1:0]         sample;
  logic                 strobe;
  logic                 sclk_q;
  logic                 update;
  logic                 pdm_sel;
  logic                 hi_oe;
  logic                 lo_oe;
  logic                 hi_pin;
  logic                 lo_pin;

  // refused while elaborating: narrower results cannot carry 14-bit conversions
  if (W < `SOAC_BITS_14) begin : g_width_check
    $error("W must hold a 14-bit result");
  end

  function automatic logic [15:0] conv_cycles(input logic [1:0] res);
    case (res)
      `SOAC_RES_10: conv_cycles = `SOAC_CONV_CYC_10;
      `SOAC_RES_12: conv_cycles = `SOAC_CONV_CYC_12;
      default:      conv_cycles = `SOAC_CONV_CYC_14;
    endcase
  endfunction

  // keep only the top bits of the chosen resolution
  function automatic logic [W-1:0] truncate(input logic [W-1:0] v, input logic [1:0] res);
    logic [W-1:0] mask;
    mask = '1;
    case (res)
      `SOAC_RES_10: mask = mask << (`SOAC_BITS_14 - `SOAC_BITS_10);
      `SOAC_RES_12: mask = mask << (`SOAC_BITS_14 - `SOAC_BITS_12);
      default:      mask = mask;
    endcase
    truncate = v & mask;
  endfunction

  // ==================================================
  // mode selection
  assign pdm_sel = (i_output_select == `SOAC_OUTSEL_PDM);              // [R15]
  // sleep needs serial commands; pdm and hostless setups fall back
  assign update  = !i_sleep_mode || pdm_sel || !i_host_present;        // [R7] [R14]

  // ==================================================
  // conversion sequencer
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state  <= soac_pkg::SOAC_IDLE;
      cnt    <= 16'h0000;
      strobe <= 1'b0;
    end else begin
      strobe <= 1'b0;
      case (state)
        soac_pkg::SOAC_IDLE: begin
          if (update || i_measure_cmd) begin
            state <= soac_pkg::SOAC_CONVERT;
            cnt   <= conv_cycles(i_cap_res);                           // [R13]
          end
        end
        soac_pkg::SOAC_CONVERT: begin
          if (cnt <= 16'h0001) begin
            state  <= soac_pkg::SOAC_DONE;
            strobe <= 1'b1;
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        soac_pkg::SOAC_DONE: state <= soac_pkg::SOAC_IDLE;
        default:             state <= soac_pkg::SOAC_IDLE;
      endcase
    end
  end

  // differential result is the pair difference, offset to mid-scale
  always_comb begin
    if (i_differential)                                                // [R11]
      sample = (i_cap_pos - i_cap_neg) + {1'b1, {(W-1){1'b0}}};
    else
      sample = i_cap_single;
  end

  // ==================================================
  // results and routing
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_cap_result   <= '0;
      o_temp_result  <= '0;
      o_pdm_valid    <= 1'b0;
      o_serial_valid <= 1'b0;
    end else begin
      o_pdm_valid    <= strobe && pdm_sel;                             // [R15]
      o_serial_valid <= strobe && !pdm_sel;
      if (strobe) begin
        o_cap_result  <= truncate(sample, i_cap_res);                  // [R13]
        o_temp_result <= truncate(i_temp_raw, i_temp_res);             // [R13]
      end
    end
  end

  // ==================================================
  // alarms; a pdm setup may claim the low alarm pin
  soac_alarm #(.W(W)) u_high (
    .i_clock      (i_clock),
    .i_resetn     (i_resetn),
    .i_enable     (1'b1),
    .i_is_high    (1'b1),
    .i_trip       (i_high_trip),
    .i_hyst       (i_high_hyst),
    .i_polarity   (i_high_pol),
    .i_open_drain (i_high_od),
    .i_strobe     (strobe),
    .i_value      (sample),
    .o_pin        (hi_pin),
    .o_pin_oe     (hi_oe),
    .o_active     ()
  );
  soac_alarm #(.W(W)) u_low (
    .i_clock      (i_clock),
    .i_resetn     (i_resetn),
    .i_enable     (!(pdm_sel && i_pdm_one_alarm)),                     // [R6]
    .i_is_high    (1'b0),
    .i_trip       (i_low_trip),
    .i_hyst       (i_low_hyst),
    .i_polarity   (i_low_pol),
    .i_open_drain (i_low_od),
    .i_strobe     (strobe),
    .i_value      (sample),
    .o_pin        (lo_pin),
    .o_pin_oe     (lo_oe),
    .o_active     ()
  );

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_alarm_high    <= 1'b0;
      o_alarm_high_oe <= 1'b0;
      o_alarm_low     <= 1'b0;
      o_alarm_low_oe  <= 1'b0;
    end else begin
      o_alarm_high    <= hi_pin;
      o_alarm_high_oe <= hi_oe;
      o_alarm_low     <= lo_pin;
      o_alarm_low_oe  <= lo_oe;
    end
  end

  // ==================================================
  // ready pin: high after a result, cleared by next conversion
  logic ready;
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      ready <= 1'b0;
    end else if (strobe) begin
      ready <= 1'b1;
    end else if (state == soac_pkg::SOAC_CONVERT) begin
      ready <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ready    <= 1'b0;
      o_ready_oe <= 1'b0;
    end else begin
      // open drain releases for high so several lines can be joined
      o_ready    <= i_ready_od ? 1'b0 : ready;                         // [R10]
      o_ready_oe <= i_ready_od ? !ready : 1'b1;                        // [R10]
    end
  end

  // ==================================================
  // serial interface hooks
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      sclk_q       <= 1'b0;
      o_miso_shift <= 1'b0;
      o_addr_ack   <= 1'b0;
    end else begin
      sclk_q <= i_sclk;
      // phase 1: change on rising so master samples on falling
      o_miso_shift <= i_spi_phase ? (i_sclk && !sclk_q)                // [R8]
                                  : (!i_sclk && sclk_q);
      o_addr_ack   <= i_addr_valid && (!i_addr_lock || i_rx_addr == i_own_addr); // [R9]
    end
  end

  // ==================================================
  // mode status
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_update_mode  <= 1'b1;
      o_config_error <= 1'b0;
    end else begin
      o_update_mode  <= update;                                        // [R7] [R14]
      // flags setups the configuring party must avoid
      o_config_error <= (i_sleep_mode && (pdm_sel || !i_host_present)) // [R14]
                        || (i_differential && (i_ref_cap_sel != 4'h0   // [R12]
                        || i_offset_cap_sel != 4'h0));
    end
  end

  a_pdm_update: assert property (@(posedge i_clock) disable iff (!i_resetn)
    pdm_sel |=> o_update_mode)                                         // [R14]
    else $error("pdm without update mode");
  a_hostless_update: assert property (@(posedge i_clock) disable iff (!i_resetn)
    !i_host_present |=> o_update_mode)                                 // [R7]
    else $error("hostless setup not in update mode");
  a_any_addr_ack: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_addr_valid && !i_addr_lock |=> o_addr_ack)                       // [R9]
    else $error("unlocked address not acknowledged");
  a_ready_od: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_ready_od |=> !o_ready)                                           // [R10]
    else $error("open-drain ready drove high");
  a_pdm_route: assert property (@(posedge i_clock) disable iff (!i_resetn)
    strobe && pdm_sel |=> o_pdm_valid && !o_serial_valid)              // [R15]
    else $error("pdm selection not routed");
  a_spi_phase: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_spi_phase && !$past(i_sclk) && i_sclk |=> o_miso_shift)           // [R8]
    else $error("phase 1 shift missing on rising edge");
endmodule // soac_top

// [test/soac_pin_load.sv]
// soac_pin_load.sv: far-side load on the alarm and ready pins (switch gates, shared ready line)
// assumes: pin levels and enables come straight from the block; released pins see a pull-up
`timescale 1ns/1ps
module soac_pin_load (
  input  wire logic i_alarm_high,    // high alarm pin level
  input  wire logic i_alarm_high_oe, // high alarm pin enable
  input  wire logic i_alarm_low,     // low alarm pin level
  input  wire logic i_alarm_low_oe,  // low alarm pin enable
  input  wire logic i_ready,         // ready pin level
  input  wire logic i_ready_oe,      // ready pin enable
  output logic      o_high_line,     // resolved high alarm line
  output logic      o_low_line,      // resolved low alarm line
  output logic      o_ready_line     // resolved shared ready line
);
  // =====================================================
  // line resolution
  // pull-ups stand in for the switch gate resistors and the shared ready bus
  assign o_high_line  = i_alarm_high_oe ? i_alarm_high : 1'b1;
  assign o_low_line   = i_alarm_low_oe ? i_alarm_low : 1'b1;
  assign o_ready_line = i_ready_oe ? i_ready : 1'b1;
endmodule // soac_pin_load

// [test/tb.sv]
// tb.sv: self-checking bench of the output, mode and alarm configuration block
// assumes: 200 MHz clock, conversion counts 16/64/256 as set in the design
`timescale 1ns/1ps
`include "soac_params.svh"
module tb;
  localparam int W = `SOAC_DATA_W;
  logic         clock, resetn, sleep, host, meas, phase, sclk, lock, addr_v, rdy_od, diff;
  logic         hi_pol, lo_pol, hi_od, lo_od, one_alarm;
  logic [1:0]   out_sel, cres, tres;
  logic [6:0]   own, rx;
  logic [3:0]   ref_sel, off_sel;
  logic [W-1:0] cap_s, cap_p, cap_n, temp_r, hi_trip, hi_hyst, lo_trip, lo_hyst;
  logic         al_hi, al_hi_oe, al_lo, al_lo_oe, rdy, rdy_oe, upd, cfg_err, ack, shift, pdm_v, ser_v;
  logic         hi_line, lo_line, rdy_line;
  logic [W-1:0] cap_o, temp_o;
  int           err_count, total_checks, cycles, k;
  logic [W-1:0] av [7] = '{14'h1800, 14'h2001, 14'h1f80, 14'h1f00, 14'h0fff, 14'h1080, 14'h1100};
  logic [1:0]   ae [7] = '{2'h0, 2'h2, 2'h2, 2'h0, 2'h1, 2'h1, 2'h0};

  soac_top soac_top_i (.i_clock(clock), .i_resetn(resetn), .i_output_select(out_sel), .i_sleep_mode(sleep),
    .i_host_present(host), .i_measure_cmd(meas), .i_spi_phase(phase), .i_sclk(sclk), .i_addr_lock(lock),
    .i_own_addr(own), .i_rx_addr(rx), .i_addr_valid(addr_v), .i_ready_od(rdy_od), .i_differential(diff),
    .i_ref_cap_sel(ref_sel), .i_offset_cap_sel(off_sel), .i_cap_res(cres), .i_temp_res(tres),
    .i_cap_single(cap_s), .i_cap_pos(cap_p), .i_cap_neg(cap_n), .i_temp_raw(temp_r), .i_high_trip(hi_trip),
    .i_high_hyst(hi_hyst), .i_low_trip(lo_trip), .i_low_hyst(lo_hyst), .i_high_pol(hi_pol), .i_low_pol(lo_pol),
    .i_high_od(hi_od), .i_low_od(lo_od), .i_pdm_one_alarm(one_alarm), .o_alarm_high(al_hi),
    .o_alarm_high_oe(al_hi_oe), .o_alarm_low(al_lo), .o_alarm_low_oe(al_lo_oe), .o_ready(rdy),
    .o_ready_oe(rdy_oe), .o_update_mode(upd), .o_config_error(cfg_err), .o_addr_ack(ack),
    .o_miso_shift(shift), .o_cap_result(cap_o), .o_temp_result(temp_o), .o_pdm_valid(pdm_v),
    .o_serial_valid(ser_v));
  soac_pin_load soac_pin_load_i (.i_alarm_high(al_hi), .i_alarm_high_oe(al_hi_oe), .i_alarm_low(al_lo),
    .i_alarm_low_oe(al_lo_oe), .i_ready(rdy), .i_ready_oe(rdy_oe), .o_high_line(hi_line),
    .o_low_line(lo_line), .o_ready_line(rdy_line));

  // =====================================================
  // clock, timeout and shared tasks
  always #2.5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input string name, input logic [W-1:0] seen, input logic [W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // counts edges up to the next result pulse; ends just after that edge
  task automatic wait_valid(input bit pdm, output int n);
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while ((pdm ? pdm_v : ser_v) !== 1'b1 && n < 600);
    chk("valid pulse", pdm ? pdm_v : ser_v, 1'b1);
  endtask
  // two results so that a config change has passed through a whole conversion
  task automatic conv(input bit pdm);
    int n;
    wait_valid(pdm, n);
    wait_valid(pdm, n);
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // =====================================================
  // main sequence
  initial begin
    clock = 1'b0; resetn = 1'b0; out_sel = 2'h0; sleep = 1'b0; host = 1'b1; meas = 1'b0; phase = 1'b1;
    sclk = 1'b0; lock = 1'b1; own = 7'h28; rx = 7'h00; addr_v = 1'b0; rdy_od = 1'b0; diff = 1'b0;
    ref_sel = 4'h0; off_sel = 4'h0; cres = 2'h2; tres = 2'h2; cap_s = 14'h1800; cap_p = 14'h0000;
    cap_n = 14'h0000; temp_r = 14'h0000; hi_pol = 1'b0; lo_pol = 1'b0; hi_od = 1'b0; lo_od = 1'b0;
    one_alarm = 1'b0; err_count = 0; total_checks = 0; cycles = 0;
    hi_trip = 14'h2000; hi_hyst = 14'h0100; lo_trip = 14'h1000; lo_hyst = 14'h0100;
    repeat (2) @(posedge clock);
    #1;
    chk("reset update mode", upd, 1'b1);
    chk("reset high pin", al_hi, 1'b0);
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    for (int r = 0; r < 3; r++) begin
      @(posedge clock);
      cres <= 2'(r);
      tres <= 2'(r);
      cap_s <= 14'h1237;
      temp_r <= 14'h2aab;
      // second gap is a full conversion at the new resolution
      wait_valid(1'b0, k);
      wait_valid(1'b0, k);
      chk("conversion period", W'(k), W'((16 << (2 * r)) + 2));
      repeat (2) @(posedge clock);
      #1;
      chk("cap result", cap_o, 14'h1237 & ((14'h3fff >> (4 - 2 * r)) << (4 - 2 * r)));
      chk("temp result", temp_o, 14'h2aab & ((14'h3fff >> (4 - 2 * r)) << (4 - 2 * r)));
    end
    @(posedge clock);
    diff <= 1'b1;
    cap_p <= 14'h1100;
    cap_n <= 14'h0100;
    conv(1'b0);
    chk("differential result", cap_o, 14'h3000);
    chk("diff caps zero", cfg_err, 1'b0);
    @(posedge clock);
    off_sel <= 4'h3;
    repeat (3) @(posedge clock);
    #1;
    chk("diff caps nonzero", cfg_err, 1'b1);
    @(posedge clock);
    off_sel <= 4'h0;
    diff <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      @(posedge clock);
      cap_s <= av[i];
      conv(1'b0);
      chk("high alarm pin", al_hi, ae[i][1]);
      chk("high alarm oe", al_hi_oe, 1'b1);
      chk("low alarm pin", al_lo, ae[i][0]);
      chk("low alarm oe", al_lo_oe, 1'b1);
    end
    @(posedge clock);
    hi_pol <= 1'b1;
    hi_od <= 1'b1;
    lo_pol <= 1'b1;
    cap_s <= 14'h2001;
    conv(1'b0);
    chk("od active high line", hi_line, 1'b0);
    chk("inverted low pin", al_lo, 1'b1);
    chk("push-pull low line", lo_line, 1'b1);
    @(posedge clock);
    cap_s <= 14'h1800;
    conv(1'b0);
    chk("od released oe", al_hi_oe, 1'b0);
    chk("od released line", hi_line, 1'b1);
    @(posedge clock);
    out_sel <= 2'h2;
    sleep <= 1'b1;
    one_alarm <= 1'b1;
    conv(1'b1);
    chk("pdm update mode", upd, 1'b1);
    chk("pdm sleep error", cfg_err, 1'b1);
    chk("pdm cap result", cap_o, 14'h1800);
    chk("pdm low alarm oe", al_lo_oe, 1'b0);
    @(posedge clock);
    out_sel <= 2'h0;
    cres <= 2'h0;
    repeat (300) @(posedge clock);
    #1;
    chk("sleep mode", upd, 1'b0);
    k = 0;
    repeat (100) begin
      @(posedge clock);
      #1;
      k += int'(ser_v === 1'b1);
    end
    chk("no result without command", W'(k), 14'h0000);
    @(posedge clock);
    meas <= 1'b1;
    @(posedge clock);
    meas <= 1'b0;
    wait_valid(1'b0, k);
    chk("command latency", W'(k), 14'h0011);
    repeat (2) @(posedge clock);
    #1;
    chk("ready push-pull", {rdy_oe, rdy}, 14'h0003);
    @(posedge clock);
    rdy_od <= 1'b1;
    host <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk("ready open drain", {rdy_oe, rdy, rdy_line}, 14'h0001);
    chk("no host update mode", upd, 1'b1);
    chk("no host sleep error", cfg_err, 1'b1);
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      lock <= (i != 0);
      rx <= (i == 2) ? 7'h28 : 7'h15;
      addr_v <= 1'b1;
      @(posedge clock);
      addr_v <= 1'b0;
      #1;
      chk("address ack", ack, (i != 1));
    end
    for (int p = 1; p >= 0; p--) begin
      @(posedge clock);
      phase <= p[0];
      @(posedge clock);
      sclk <= 1'b1;
      @(posedge clock);
      #1;
      chk("shift after rise", shift, p[0]);
      @(posedge clock);
      sclk <= 1'b0;
      @(posedge clock);
      #1;
      chk("shift after fall", shift, !p[0]);
    end
    tally_and_finish();
  end
endmodule // tb
